// >>> shared/asp_pkg.sv
// constants, register map and field layout of the asynchronous serial port
//
// What this block does
// - two instances exist; the secondary one has only its serial in and out lines, no flow control.
// - a baud divider set by software divides the clock into separate receive and transmit enables.
// - every frame is one start bit, eight data bits and one or two stop bits as configured.
// - parity is even, odd or none; when used, one parity bit sits between data and stop.
// - the line carries start, then data from bit 7 down to bit 0, then parity, then stop.
// - transmit and receive each have their own identical first-in first-out queue.
// - the transmitter takes a byte from its queue, frames it and shifts it out at the set rate.
// - the receiver samples the line, strips the framing bits and puts the byte in its queue.
// - every received character is checked for stop bits, and for parity when enabled; an error sets its status flag, which raises the interrupt only if unmasked.
// - echo, local loopback and remote loopback diagnostic modes are available.
// - flow control acts only when software enables it; otherwise clear-to-send is ignored.
// - with flow control on, a new character starts only while clear-to-send is asserted.
// - with flow control on, request-to-send is asserted only while the receive queue has room.
`default_nettype none

package asp_pkg;

	// ------------------------------------------------------------------
	// register byte addresses
	// ------------------------------------------------------------------
	localparam logic [7:0] ASP_OFS_DATA     = 8'h00;
	localparam logic [7:0] ASP_OFS_CTRL     = 8'h04;
	localparam logic [7:0] ASP_OFS_BAUD     = 8'h08;
	localparam logic [7:0] ASP_OFS_STATUS   = 8'h0C;
	localparam logic [7:0] ASP_OFS_IRQ_STAT = 8'h10;
	localparam logic [7:0] ASP_OFS_IRQ_MASK = 8'h14;

	// ------------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------------
	localparam int ASP_CTRL_STOP2   = 0;
	localparam int ASP_CTRL_PAR_EN  = 1;
	localparam int ASP_CTRL_PAR_ODD = 2;
	localparam int ASP_CTRL_MODE_LO = 3;
	localparam int ASP_CTRL_FLOW_EN = 5;
	localparam int ASP_CTRL_W       = 6;

	// diagnostic modes in ctrl[4:3]
	typedef enum logic [1:0] {
		ASP_MODE_NORMAL = 2'b00,
		ASP_MODE_ECHO   = 2'b01,
		ASP_MODE_LOCAL  = 2'b10,
		ASP_MODE_REMOTE = 2'b11
	} asp_mode_t;

	// ------------------------------------------------------------------
	// status and interrupt fields
	// ------------------------------------------------------------------
	localparam int ASP_ST_TX_FULL  = 0;
	localparam int ASP_ST_TX_EMPTY = 1;
	localparam int ASP_ST_RX_FULL  = 2;
	localparam int ASP_ST_RX_EMPTY = 3;
	localparam int ASP_ST_TX_BUSY  = 4;
	localparam int ASP_ST_RX_BUSY  = 5;

	localparam int ASP_IRQ_PARITY  = 0;
	localparam int ASP_IRQ_FRAMING = 1;
	localparam int ASP_IRQ_OVERRUN = 2;
	localparam int ASP_IRQ_RX_DATA = 3;
	localparam int ASP_IRQ_W       = 4;

	// ------------------------------------------------------------------
	// reset values and timing
	// ------------------------------------------------------------------
	localparam logic [ASP_CTRL_W-1:0] ASP_CTRL_RST = 6'h00;
	localparam logic [15:0]           ASP_BAUD_RST = 16'h0035;
	localparam logic [ASP_IRQ_W-1:0]  ASP_MASK_RST = 4'h0;
	localparam logic [3:0]            ASP_OS_LAST  = 4'hF;
	localparam logic [3:0]            ASP_OS_MID   = 4'h7;

endpackage : asp_pkg

`default_nettype wire

// >>> src/asp_serial_port.sv
// asynchronous serial port: baud divider, queues, framer, deframer, registers
//
// Implementation choices: the strobed register port and the register offsets.
`default_nettype none

module asp_serial_port
	import asp_pkg::*;
#(
	parameter int DEPTH     = 16,
	parameter int FLOW_PINS = 1,
	parameter int RTS_FREE  = 4
) (
	// clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_reset_n,
	// register port
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	// interrupt
	output logic             o_irq,
	// serial line
	input  wire logic        i_serial_in,
	output logic             o_serial_out,
	// flow control
	input  wire logic        i_cts,
	output logic             o_rts
);

	localparam int AW = $clog2(DEPTH);

	typedef enum logic [4:0] {
		ASP_S_IDLE  = 5'b00001,
		ASP_S_START = 5'b00010,
		ASP_S_DATA  = 5'b00100,
		ASP_S_PAR   = 5'b01000,
		ASP_S_STOP  = 5'b10000
	} asp_state_t;

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	logic [ASP_CTRL_W-1:0] ctrl_q,     ctrl_d;
	logic [15:0]           baud_q,     baud_d;
	logic [ASP_IRQ_W-1:0]  stat_q,     stat_d;
	logic [ASP_IRQ_W-1:0]  mask_q,     mask_d;
	logic [31:0]           rdata_q,    rdata_d;
	logic                  irq_q,      irq_d;
	logic [15:0]           div_q,      div_d;
	logic [3:0]            sub_q,      sub_d;
	logic                  rx_tick,    tx_tick;
	logic [7:0]            tx_mem     [DEPTH];
	logic [7:0]            rx_mem     [DEPTH];
	logic [AW:0]           txw_q,      txw_d,     txr_q,   txr_d;
	logic [AW:0]           rxw_q,      rxw_d,     rxr_q,   rxr_d;
	logic [AW:0]           tx_cnt,     rx_cnt;
	logic                  tx_full,    tx_empty,  rx_full, rx_empty;
	logic                  tx_push,    tx_pop,    rx_push, rx_pop;
	asp_state_t            ts_q,       ts_d,      rs_q,    rs_d;
	logic [7:0]            tsh_q,      tsh_d,     rsh_q,   rsh_d;
	logic [2:0]            tbit_q,     tbit_d,    rbit_q,  rbit_d;
	logic                  tpar_q,     tpar_d,    rpar_q,  rpar_d;
	logic                  tstop_q,    tstop_d,   rstop_q, rstop_d;
	logic                  tline_q,    tline_d;
	logic [3:0]            ros_q,      ros_d;
	logic                  rperr_q,    rperr_d;
	logic                  rdone,      rferr;
	logic                  out_q,      out_d,     rts_q,   rts_d;
	logic                  flow_on,    rx_in;
	asp_mode_t             mode;

	assign mode    = asp_mode_t'(ctrl_q[ASP_CTRL_MODE_LO +: 2]);
	assign flow_on = (FLOW_PINS != 0) && ctrl_q[ASP_CTRL_FLOW_EN];
	assign rx_in   = (mode == ASP_MODE_LOCAL) ? tline_q : i_serial_in;

	// ------------------------------------------------------------------
	// baud generator: 16x receive enable, 1x transmit enable
	// ------------------------------------------------------------------
	always_comb begin
		rx_tick = (div_q == 16'h0000);
		tx_tick = rx_tick && (sub_q == ASP_OS_LAST);
		div_d   = rx_tick ? baud_q : div_q - 16'h0001;
		sub_d   = rx_tick ? sub_q + 4'h1 : sub_q;
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			div_q <= 16'h0000;
			sub_q <= 4'h0;
		end else begin
			div_q <= div_d;
			sub_q <= sub_d;
		end
	end

	// ------------------------------------------------------------------
	// queues
	// ------------------------------------------------------------------
	always_comb begin
		tx_cnt   = txw_q - txr_q;
		rx_cnt   = rxw_q - rxr_q;
		tx_full  = (tx_cnt == (AW+1)'(DEPTH));
		rx_full  = (rx_cnt == (AW+1)'(DEPTH));
		tx_empty = (tx_cnt == '0);
		rx_empty = (rx_cnt == '0);
		tx_push  = i_wr && (i_addr == ASP_OFS_DATA) && !tx_full;
		rx_pop   = i_rd && (i_addr == ASP_OFS_DATA) && !rx_empty;
		rx_push  = rdone && (mode != ASP_MODE_REMOTE) && !rx_full;
		txw_d    = tx_push ? txw_q + 1'b1 : txw_q;
		txr_d    = tx_pop ? txr_q + 1'b1 : txr_q;
		rxw_d    = rx_push ? rxw_q + 1'b1 : rxw_q;
		rxr_d    = rx_pop ? rxr_q + 1'b1 : rxr_q;
	end

	always_ff @(posedge i_mclk) begin
		if (tx_push) begin
			tx_mem[txw_q[AW-1:0]] <= i_wdata[7:0];
		end
		if (rx_push) begin
			rx_mem[rxw_q[AW-1:0]] <= rsh_q;
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			txw_q <= '0;
			txr_q <= '0;
			rxw_q <= '0;
			rxr_q <= '0;
		end else begin
			txw_q <= txw_d;
			txr_q <= txr_d;
			rxw_q <= rxw_d;
			rxr_q <= rxr_d;
		end
	end

	// ------------------------------------------------------------------
	// transmitter
	// ------------------------------------------------------------------
	always_comb begin
		ts_d    = ts_q;
		tsh_d   = tsh_q;
		tbit_d  = tbit_q;
		tpar_d  = tpar_q;
		tstop_d = tstop_q;
		tline_d = tline_q;
		tx_pop  = 1'b0;
		if (tx_tick) begin
			unique case (ts_q)
				ASP_S_IDLE: begin
					tline_d = 1'b1;
					// echo and remote loopback own the line, so the framer holds off
					if (!tx_empty && (!flow_on || i_cts) && (mode[0] == 1'b0)) begin
						tx_pop  = 1'b1;
						tsh_d   = tx_mem[txr_q[AW-1:0]];
						tline_d = 1'b0;
						tpar_d  = ctrl_q[ASP_CTRL_PAR_ODD];
						ts_d    = ASP_S_START;
					end
				end
				ASP_S_START: begin
					tline_d = tsh_q[7];
					tpar_d  = tpar_q ^ tsh_q[7];
					tsh_d   = {tsh_q[6:0], 1'b0};
					tbit_d  = 3'd7;
					ts_d    = ASP_S_DATA;
				end
				ASP_S_DATA: begin
					if (tbit_q == 3'd0) begin
						tstop_d = ctrl_q[ASP_CTRL_STOP2];
						if (ctrl_q[ASP_CTRL_PAR_EN]) begin
							tline_d = tpar_q;
							ts_d    = ASP_S_PAR;
						end else begin
							tline_d = 1'b1;
							ts_d    = ASP_S_STOP;
						end
					end else begin
						tline_d = tsh_q[7];
						tpar_d  = tpar_q ^ tsh_q[7];
						tsh_d   = {tsh_q[6:0], 1'b0};
						tbit_d  = tbit_q - 3'd1;
					end
				end
				ASP_S_PAR: begin
					tline_d = 1'b1;
					ts_d    = ASP_S_STOP;
				end
				ASP_S_STOP: begin
					tline_d = 1'b1;
					if (tstop_q) begin
						tstop_d = 1'b0;
					end else begin
						ts_d = ASP_S_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ts_q    <= ASP_S_IDLE;
			tsh_q   <= 8'h00;
			tbit_q  <= 3'd0;
			tpar_q  <= 1'b0;
			tstop_q <= 1'b0;
			tline_q <= 1'b1;
		end else begin
			ts_q    <= ts_d;
			tsh_q   <= tsh_d;
			tbit_q  <= tbit_d;
			tpar_q  <= tpar_d;
			tstop_q <= tstop_d;
			tline_q <= tline_d;
		end
	end

	// ------------------------------------------------------------------
	// receiver: 16x oversampling, bits taken at mid-cell
	// ------------------------------------------------------------------
	always_comb begin
		rs_d    = rs_q;
		rsh_d   = rsh_q;
		rbit_d  = rbit_q;
		rpar_d  = rpar_q;
		rstop_d = rstop_q;
		ros_d   = ros_q;
		rperr_d = rperr_q;
		rdone   = 1'b0;
		rferr   = 1'b0;
		if (rx_tick) begin
			ros_d = ros_q + 4'h1;
			unique case (rs_q)
				ASP_S_IDLE: begin
					ros_d = 4'h0;
					if (!rx_in) begin
						rs_d = ASP_S_START;
					end
				end
				ASP_S_START: begin
					if (ros_q == ASP_OS_MID) begin
						ros_d   = 4'h0;
						rbit_d  = 3'd7;
						rpar_d  = ctrl_q[ASP_CTRL_PAR_ODD];
						rperr_d = 1'b0;
						rs_d    = rx_in ? ASP_S_IDLE : ASP_S_DATA;
					end
				end
				ASP_S_DATA: begin
					if (ros_q == ASP_OS_LAST) begin
						rsh_d  = {rsh_q[6:0], rx_in};
						rpar_d = rpar_q ^ rx_in;
						rbit_d = rbit_q - 3'd1;
						if (rbit_q == 3'd0) begin
							rstop_d = ctrl_q[ASP_CTRL_STOP2];
							rs_d    = ctrl_q[ASP_CTRL_PAR_EN] ? ASP_S_PAR : ASP_S_STOP;
						end
					end
				end
				ASP_S_PAR: begin
					if (ros_q == ASP_OS_LAST) begin
						rperr_d = rpar_q ^ rx_in;
						rs_d    = ASP_S_STOP;
					end
				end
				ASP_S_STOP: begin
					if (ros_q == ASP_OS_LAST) begin
						if (!rx_in) begin
							rferr = 1'b1;
							rdone = 1'b1;
							rs_d  = ASP_S_IDLE;
						end else if (rstop_q) begin
							rstop_d = 1'b0;
						end else begin
							rdone = 1'b1;
							rs_d  = ASP_S_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rs_q    <= ASP_S_IDLE;
			rsh_q   <= 8'h00;
			rbit_q  <= 3'd0;
			rpar_q  <= 1'b0;
			rstop_q <= 1'b0;
			ros_q   <= 4'h0;
			rperr_q <= 1'b0;
		end else begin
			rs_q    <= rs_d;
			rsh_q   <= rsh_d;
			rbit_q  <= rbit_d;
			rpar_q  <= rpar_d;
			rstop_q <= rstop_d;
			ros_q   <= ros_d;
			rperr_q <= rperr_d;
		end
	end

	// ------------------------------------------------------------------
	// registers, interrupt and pins
	// ------------------------------------------------------------------
	always_comb begin
		ctrl_d  = ctrl_q;
		baud_d  = baud_q;
		mask_d  = mask_q;
		stat_d  = stat_q;
		rdata_d = 32'h0000_0000;
		if (i_wr) begin
			unique case (i_addr)
				ASP_OFS_CTRL:     ctrl_d = i_wdata[ASP_CTRL_W-1:0];
				ASP_OFS_BAUD:     baud_d = i_wdata[15:0];
				ASP_OFS_IRQ_MASK: mask_d = i_wdata[ASP_IRQ_W-1:0];
				ASP_OFS_IRQ_STAT: stat_d = stat_q & ~i_wdata[ASP_IRQ_W-1:0];
				default: ;
			endcase
		end
		// hardware events win over a same-cycle clear
		stat_d[ASP_IRQ_PARITY]  = stat_d[ASP_IRQ_PARITY] | (rdone && rperr_q);
		stat_d[ASP_IRQ_FRAMING] = stat_d[ASP_IRQ_FRAMING] | rferr;
		stat_d[ASP_IRQ_OVERRUN] = stat_d[ASP_IRQ_OVERRUN] | (rdone && rx_full &&
			(mode != ASP_MODE_REMOTE));
		stat_d[ASP_IRQ_RX_DATA] = stat_d[ASP_IRQ_RX_DATA] | rx_push;
		if (i_rd) begin
			unique case (i_addr)
				ASP_OFS_DATA:     rdata_d = rx_pop ? {24'h00_0000, rx_mem[rxr_q[AW-1:0]]}
				                                   : 32'h0000_0000;
				ASP_OFS_CTRL:     rdata_d[ASP_CTRL_W-1:0] = ctrl_q;
				ASP_OFS_BAUD:     rdata_d[15:0] = baud_q;
				ASP_OFS_STATUS:   rdata_d[5:0] = {rs_q != ASP_S_IDLE, ts_q != ASP_S_IDLE,
				                                  rx_empty, rx_full, tx_empty, tx_full};
				ASP_OFS_IRQ_STAT: rdata_d[ASP_IRQ_W-1:0] = stat_q;
				ASP_OFS_IRQ_MASK: rdata_d[ASP_IRQ_W-1:0] = mask_q;
				default: ;
			endcase
		end
		irq_d = |(stat_d & mask_d);
		// echo and remote loopback mirror the incoming line; local keeps the pin idle
		unique case (mode)
			ASP_MODE_NORMAL: out_d = tline_d;
			ASP_MODE_LOCAL:  out_d = 1'b1;
			default:         out_d = i_serial_in;
		endcase
		rts_d = flow_on && (((AW+1)'(DEPTH) - rx_cnt) >= (AW+1)'(RTS_FREE));
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctrl_q  <= ASP_CTRL_RST;
			baud_q  <= ASP_BAUD_RST;
			mask_q  <= ASP_MASK_RST;
			stat_q  <= '0;
			rdata_q <= 32'h0000_0000;
			irq_q   <= 1'b0;
			out_q   <= 1'b1;
			rts_q   <= 1'b0;
		end else begin
			ctrl_q  <= ctrl_d;
			baud_q  <= baud_d;
			mask_q  <= mask_d;
			stat_q  <= stat_d;
			rdata_q <= rdata_d;
			irq_q   <= irq_d;
			out_q   <= out_d;
			rts_q   <= rts_d;
		end
	end

	assign o_rdata      = rdata_q;
	assign o_irq        = irq_q;
	assign o_serial_out = out_q;
	assign o_rts        = rts_q;

endmodule : asp_serial_port

`default_nettype wire

// >>> sim/asp_serial_port_assertions.sv
// pin-level checks for the asynchronous serial port
`default_nettype none

module asp_chk
	import asp_pkg::*;
(
	// clock and reset
	input wire logic        i_mclk,
	input wire logic        i_reset_n,
	// register port
	input wire logic [7:0]  i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic        o_irq,
	// line and flow control
	input wire logic        i_serial_in,
	input wire logic        o_serial_out,
	input wire logic        i_cts,
	input wire logic        o_rts
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [5:0]  ctrl_q, ctrl_d;
	logic [15:0] baud_q, baud_d;
	logic [3:0]  mask_q, mask_d;
	logic [31:0] ctslo_q, ctslo_d;
	int          lim;

	// ------------------------------------------------------------
	// shadow of written settings
	// ------------------------------------------------------------
	always_comb begin
		ctrl_d = (i_wr && i_addr == ASP_OFS_CTRL) ? i_wdata[5:0] : ctrl_q;
		baud_d = (i_wr && i_addr == ASP_OFS_BAUD) ? i_wdata[15:0] : baud_q;
		mask_d = (i_wr && i_addr == ASP_OFS_IRQ_MASK) ? i_wdata[3:0] : mask_q;
		ctslo_d = (ctrl_q[5] && ctrl_q[4:3] == ASP_MODE_NORMAL && !i_cts) ? ctslo_q + 1 : '0;
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctrl_q <= ASP_CTRL_RST;
			baud_q <= ASP_BAUD_RST;
			mask_q <= ASP_MASK_RST;
			ctslo_q <= '0;
		end else begin
			ctrl_q <= ctrl_d;
			baud_q <= baud_d;
			mask_q <= mask_d;
			ctslo_q <= ctslo_d;
		end
	end

	// longest frame is twelve bits of sixteen ticks
	assign lim = 192 * (int'(baud_q) + 1) + 4;

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_reset_n);

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data not zero outside a read answer");
	a_unmapped_zero: assert property (i_rd && i_addr > ASP_OFS_IRQ_MASK |=> o_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_ctrl_readback: assert property (i_rd && i_addr == ASP_OFS_CTRL |=>
		o_rdata == {26'h0, $past(ctrl_q)}) else $error("control readback wrong");
	a_baud_readback: assert property (i_rd && i_addr == ASP_OFS_BAUD |=>
		o_rdata == {16'h0, $past(baud_q)}) else $error("divider readback wrong");
	a_rts_disabled: assert property (!ctrl_q[5] && !$past(ctrl_q[5])
		&& !$past(ctrl_q[5], 2) |-> !o_rts) else $error("request-to-send raised with flow off");
	a_cts_holds: assert property (ctslo_q > lim |-> o_serial_out)
		else $error("frame sent while clear-to-send low");
	a_local_quiet: assert property (ctrl_q[4:3] == ASP_MODE_LOCAL &&
		$past(ctrl_q[4:3]) == ASP_MODE_LOCAL |-> o_serial_out)
		else $error("line not idle in local loop");
	a_mirror_line: assert property ((ctrl_q[3] && $stable(i_serial_in)) [*8] |->
		o_serial_out == i_serial_in) else $error("line not mirrored");
	a_irq_masked: assert property (mask_q == 4'h0 && $past(mask_q) == 4'h0 |-> !o_irq)
		else $error("interrupt with all sources masked");

endmodule // asp_chk

bind asp_serial_port asp_chk chk_u (
	.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
	.i_serial_in(i_serial_in), .o_serial_out(o_serial_out), .i_cts(i_cts), .o_rts(o_rts)
);

`default_nettype wire

// >>> sim/asp_far_end.sv
// far serial device that sends framed bytes toward the port
`default_nettype none

module asp_far_end #(
	parameter int BIT_CLKS = 16
) (
	input  wire logic i_mclk,
	output logic      o_line
);
	timeunit 1ns;
	timeprecision 1ps;

	initial o_line = 1'b1;

	// same stop count and parity as the port; faults only on request
	task automatic send(input logic [7:0] b, input logic [5:0] cfg, input logic bad_p,
		input logic bad_s);
		logic [11:0] f;
		int          n;
		f = cfg[1] ? {1'b0, b, ^b ^ cfg[2] ^ bad_p, 2'b11} : {1'b0, b, 3'b111};
		n = 10 + int'(cfg[1]) + int'(cfg[0]);
		f[12 - n] = !bad_s;
		for (int i = 0; i < n; i++) begin
			@(posedge i_mclk);
			o_line <= f[11 - i];
			repeat (BIT_CLKS - 1) @(posedge i_mclk);
		end
		@(posedge i_mclk);
		o_line <= 1'b1;
	endtask

endmodule // asp_far_end

`default_nettype wire

// >>> sim/asp_serial_port_test.sv
// self-checking bench for the asynchronous serial port
`default_nettype none

module asp_serial_port_test
	import asp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int DEPTH    = 4;
	localparam int RTS_FREE = 2;

	logic        i_mclk    = 1'b0;
	logic        i_reset_n = 1'b0;
	logic [7:0]  i_addr    = 8'h00;
	logic [31:0] i_wdata   = 32'h0;
	logic        i_wr      = 1'b0;
	logic        i_rd      = 1'b0;
	logic        i_cts     = 1'b1;
	wire         i_serial_in;
	logic [31:0] o_rdata;
	logic        o_irq;
	logic        o_serial_out;
	logic        o_rts;
	int          err_count   = 0;
	int          comparisons = 0;
	logic [31:0] seed        = 32'h0001_0CB5;

	asp_serial_port #(.DEPTH(DEPTH), .FLOW_PINS(1), .RTS_FREE(RTS_FREE)) dut_u (
		.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
		.i_serial_in(i_serial_in), .o_serial_out(o_serial_out), .i_cts(i_cts), .o_rts(o_rts)
	);
	asp_far_end #(.BIT_CLKS(16)) far_u (.i_mclk(i_mclk), .o_line(i_serial_in));

	always #5 i_mclk = ~i_mclk;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] nxt();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction

	// line bits in order, idle level after the stop bits
	function automatic logic [31:0] fr(input logic [7:0] b, input logic [5:0] c);
		return c[1] ? {20'h0, 1'b0, b, ^b ^ c[2], 2'b11} : {20'h0, 1'b0, b, 3'b111};
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask

	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		@(posedge i_mclk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 check(what, o_rdata, exp);
	endtask

	task automatic cap(output logic [31:0] f);
		int n;
		n = 0;
		f = 32'h0;
		while (o_serial_out !== 1'b0 && n < 4000) begin
			@(posedge i_mclk);
			#1 n++;
		end
		repeat (8) @(posedge i_mclk);
		for (int i = 11; i >= 0; i--) begin
			#1 f[i] = o_serial_out;
			repeat (16) @(posedge i_mclk);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge i_mclk);
		err_count++;
		summarize();
	end

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		logic [31:0] f;
		logic [7:0]  b;
		logic [5:0]  c;
		logic        bp, bs;
		logic [7:0]  rq [5];
		repeat (5) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		rdchk("ctrl", ASP_OFS_CTRL, 32'h0);
		rdchk("baud", ASP_OFS_BAUD, {16'h0, ASP_BAUD_RST});
		rdchk("status", ASP_OFS_STATUS, 32'h0000_000A);
		rdchk("unmapped", 8'h18, 32'h0);
		check("idle line", {31'h0, o_serial_out}, 32'h1);
		wr(ASP_OFS_BAUD, 32'h0);
		$display("test reset done");
		for (int k = 0; k < 8; k++) begin
			c = 6'(k);
			bp = (k == 3 || k == 6);
			bs = (k == 4 || k == 5);
			wr(ASP_OFS_CTRL, {26'h0, c});
			b = nxt();
			wr(ASP_OFS_DATA, {24'h0, b});
			cap(f);
			check("tx frame", f, fr(b, c));
			b = nxt();
			far_u.send(b, c, bp, bs);
			rdchk("rx flags", ASP_OFS_IRQ_STAT, {28'h0, 2'b10, bs, bp});
			rdchk("rx byte", ASP_OFS_DATA, {24'h0, b});
			wr(ASP_OFS_IRQ_STAT, 32'h0000_000F);
		end
		$display("test framing done");
		wr(ASP_OFS_IRQ_MASK, 32'h1);
		b = nxt();
		far_u.send(b, c, 1'b1, 1'b0);
		repeat (2) @(posedge i_mclk);
		#1 check("irq set", {31'h0, o_irq}, 32'h1);
		wr(ASP_OFS_IRQ_STAT, 32'h1);
		repeat (2) @(posedge i_mclk);
		#1 check("irq clear", {31'h0, o_irq}, 32'h0);
		rdchk("w1c", ASP_OFS_IRQ_STAT, 32'h8);
		rdchk("pop", ASP_OFS_DATA, {24'h0, b});
		wr(ASP_OFS_IRQ_STAT, 32'h0000_000F);
		$display("test interrupt done");
		wr(ASP_OFS_CTRL, 32'h10);
		b = nxt();
		wr(ASP_OFS_DATA, {24'h0, b});
		repeat (250) @(posedge i_mclk);
		#1 check("local line", {31'h0, o_serial_out}, 32'h1);
		rdchk("local byte", ASP_OFS_DATA, {24'h0, b});
		for (int m = 1; m < 4; m += 2) begin
			wr(ASP_OFS_CTRL, 32'(m) << 3);
			b = nxt();
			fork
				far_u.send(b, 6'h0, 1'b0, 1'b0);
				cap(f);
			join
			check("mirror", f, fr(b, 6'h0));
			rdchk("mirror rx", ASP_OFS_DATA, (m == 1) ? {24'h0, b} : 32'h0);
		end
		wr(ASP_OFS_IRQ_STAT, 32'h0000_000F);
		$display("test loops done");
		wr(ASP_OFS_CTRL, 32'h20);
		repeat (3) @(posedge i_mclk);
		#1 check("rts room", {31'h0, o_rts}, 32'h1);
		@(posedge i_mclk);
		i_cts <= 1'b0;
		b = nxt();
		wr(ASP_OFS_DATA, {24'h0, b});
		repeat (300) @(posedge i_mclk);
		#1 check("cts hold", {31'h0, o_serial_out}, 32'h1);
		@(posedge i_mclk);
		i_cts <= 1'b1;
		cap(f);
		check("cts frame", f, fr(b, 6'h20));
		for (int i = 0; i < 5; i++) begin
			rq[i] = nxt();
			far_u.send(rq[i], 6'h20, 1'b0, 1'b0);
			repeat (3) @(posedge i_mclk);
			#1 check("rts level", {31'h0, o_rts}, {31'h0, DEPTH - i - 1 >= RTS_FREE});
		end
		rdchk("rx full", ASP_OFS_STATUS, 32'h0000_0006);
		rdchk("overrun", ASP_OFS_IRQ_STAT, 32'h0000_000C);
		for (int i = 0; i < DEPTH; i++)
			rdchk("drain", ASP_OFS_DATA, {24'h0, rq[i]});
		repeat (2) @(posedge i_mclk);
		#1 check("rts back", {31'h0, o_rts}, 32'h1);
		wr(ASP_OFS_CTRL, 32'h0);
		repeat (3) @(posedge i_mclk);
		#1 check("rts off", {31'h0, o_rts}, 32'h0);
		@(posedge i_mclk);
		i_cts <= 1'b0;
		b = nxt();
		wr(ASP_OFS_DATA, {24'h0, b});
		cap(f);
		check("no flow frame", f, fr(b, 6'h0));
		$display("test flow done");
		summarize();
	end

endmodule // asp_serial_port_test

`default_nettype wire
